/* File: hw/opactl_top.sv */
// Op amp digital control: register file, override qualification and analog controls.
// Assumes an Avalon-MM master on the same clock; analog controls feed the amplifier macro.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module opactl_top
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [opactl_pkg::NUM_OR_SOURCES-1:0] overrideSources,
	output opactl_pkg::opactl_analog_t analogCtrl
);
	logic [7:0] control_q;
	logic [opactl_pkg::CHS_W-1:0] negSel_q;
	logic [opactl_pkg::CHS_W-1:0] posSel_q;
	logic [opactl_pkg::SRC_W-1:0] orsSel_q;
	logic answered_q;
	logic [31:0] readdata_q;
	logic overrideTrue;
	opactl_pkg::opactl_ctrl_t ctrl;
	opactl_pkg::opactl_analog_t analog_d;
	opactl_pkg::opactl_analog_t analog_q;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a[3:2] == ofs[3:2]);
	endfunction

	// ==========================================
	// Bus handshake
	// One wait cycle per access keeps read data registered.
	assign waitrequest = (read || write) && !answered_q;
	wire accept = (read || write) && answered_q;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			answered_q <= 1'b0;
		end
		else
		begin
			answered_q <= (read || write) && !answered_q;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			control_q <= opactl_pkg::CONTROL_RESET;
			negSel_q <= opactl_pkg::CHS_RESET;
			posSel_q <= opactl_pkg::CHS_RESET;
			orsSel_q <= opactl_pkg::SRC_RESET;
		end
		else if (accept && write && byteenable[0])
		begin
			if (hit(address, opactl_pkg::OFS_CONTROL))
			begin
				control_q <= writedata[7:0] & opactl_pkg::CONTROL_WMASK;
			end
			if (hit(address, opactl_pkg::OFS_NEG_SEL))
			begin
				negSel_q <= writedata[opactl_pkg::CHS_W-1:0];
			end
			if (hit(address, opactl_pkg::OFS_POS_SEL))
			begin
				posSel_q <= writedata[opactl_pkg::CHS_W-1:0];
			end
			if (hit(address, opactl_pkg::OFS_ORS_SEL))
			begin
				orsSel_q <= writedata[opactl_pkg::SRC_W-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			readdata_q <= opactl_pkg::READ_FILL;
		end
		else if (read && !answered_q)
		begin
			readdata_q <= opactl_pkg::READ_FILL;
			if (hit(address, opactl_pkg::OFS_CONTROL))
			begin
				readdata_q[7:0] <= control_q;
			end
			else if (hit(address, opactl_pkg::OFS_NEG_SEL))
			begin
				readdata_q[opactl_pkg::CHS_W-1:0] <= negSel_q;
			end
			else if (hit(address, opactl_pkg::OFS_POS_SEL))
			begin
				readdata_q[opactl_pkg::CHS_W-1:0] <= posSel_q;
			end
			else if (hit(address, opactl_pkg::OFS_ORS_SEL))
			begin
				readdata_q[opactl_pkg::SRC_W-1:0] <= orsSel_q;
			end
		end
	end
	assign readdata = readdata_q;

	// ==========================================
	// Override qualification
	always_comb
	begin
		ctrl.enable = control_q[opactl_pkg::BIT_ENABLE];
		ctrl.unityGain = control_q[opactl_pkg::BIT_UG];
		ctrl.polarity = control_q[opactl_pkg::BIT_POL];
		ctrl.mode = opactl_pkg::opactl_mode_t'(control_q[1:0]);
	end

	opactl_source_mux u_mux
	(
		.clock(clock),
		.nrst(nrst),
		.sources(overrideSources),
		.code(orsSel_q),
		.polarity(ctrl.polarity),
		.active(overrideTrue)
	);

	// ==========================================
	// Analog controls
	// Nothing here depends on a sleep signal, so control carries on in sleep.
	always_comb
	begin
		analog_d.ampPower = ctrl.enable;
		analog_d.portDriverHighZ = ctrl.enable;
		analog_d.ampOutEnable = ctrl.enable;
		analog_d.feedbackClosed = ctrl.unityGain;
		analog_d.invSource = negSel_q;
		analog_d.nonInvSource = posSel_q;
		// The override is recomputed every cycle, so it lapses unaided.
		if (overrideTrue)
		begin
			case (ctrl.mode)
				opactl_pkg::OPACTL_OR_TRISTATE:
				begin
					analog_d.ampOutEnable = 1'b0;
				end
				opactl_pkg::OPACTL_OR_UNITY:
				begin
					analog_d.feedbackClosed = 1'b1;
				end
				default:
				begin
					analog_d.ampOutEnable = ctrl.enable;
				end
			endcase
		end
		analog_d.invPinConnected = !analog_d.feedbackClosed;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			analog_q <= '0;
		end
		else
		begin
			analog_q <= analog_d;
		end
	end
	assign analogCtrl = analog_q;
endmodule

/* File: shared/opactl_pkg.sv */
// Constants, register map and carrier types for the op amp control block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
// Notes on behaviour
// - Enable bit 7 turns the amplifier on; clear keeps it off and unpowered.
// - While enabled, the output pin's port driver is held in high impedance.
// - Unity gain bit 4 ties output to inverting input and frees that pin.
// - Inverting and noninverting inputs come from two independent select registers.
// - Override mode 00 off, 01 tri-state output, 10 unity gain, 11 reserved.
// - Override acts only when a mode is selected and the source is true.
// - Override source is picked from peripheral outputs by its own select register.
// - Polarity bit 2 set means high source is true; clear means low.
// - Any reset returns all control registers to reset values, amplifier off.
// - Sleep does not stop the amplifier or its control behaviour.
// - Control bits 6-5 and 3 read zero and ignore writes.
// - Override source code is five bits; codes 10110 to 11111 are reserved.
package opactl_pkg;
	// ==========================================
	// Register map
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_NEG_SEL = 4'h4;
	localparam logic [3:0] OFS_POS_SEL = 4'h8;
	localparam logic [3:0] OFS_ORS_SEL = 4'hc;
	// ==========================================
	// Field layout and reset values
	localparam int BIT_ENABLE = 7;
	localparam int BIT_UG = 4;
	localparam int BIT_POL = 2;
	localparam logic [7:0] CONTROL_WMASK = 8'h97;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int SRC_W = 5;
	localparam int CHS_W = 4;
	localparam int NUM_OR_SOURCES = 22;
	localparam logic [4:0] SRC_RESET = 5'h00;
	localparam logic [3:0] CHS_RESET = 4'h0;
	localparam logic [31:0] READ_FILL = 32'h00000000;

	typedef enum logic [1:0] {
		OPACTL_OR_NONE,
		OPACTL_OR_TRISTATE,
		OPACTL_OR_UNITY,
		OPACTL_OR_RESERVED
	} opactl_mode_t;

	typedef struct packed {
		logic enable;
		logic unityGain;
		logic polarity;
		opactl_mode_t mode;
	} opactl_ctrl_t;

	typedef struct packed {
		logic ampPower;
		logic ampOutEnable;
		logic portDriverHighZ;
		logic feedbackClosed;
		logic invPinConnected;
		logic [CHS_W-1:0] invSource;
		logic [CHS_W-1:0] nonInvSource;
	} opactl_analog_t;
endpackage

/* File: hw/opactl_source_mux.sv */
// Override source selector with qualified, registered result.
// Assumes the peripheral outputs are synchronous to the block clock.
`timescale 1ns/1ps
module opactl_source_mux
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [opactl_pkg::NUM_OR_SOURCES-1:0] sources,
	input wire logic [opactl_pkg::SRC_W-1:0] code,
	input wire logic polarity,
	output logic active
);
	logic picked;

	// ==========================================
	// Selection
	always_comb
	begin
		picked = 1'b0;
		// Reserved codes select nothing and read as a low source, which triggers override when polarity is clear.
		if (code < 5'(opactl_pkg::NUM_OR_SOURCES))
		begin
			picked = sources[code];
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			active <= 1'b0;
		end
		else
		begin
			active <= polarity ? picked : !picked;
		end
	end
endmodule

/* File: test/opactl_checker.sv */
// Assertions on the op amp control block's ports.
// Assumes it is bound to opactl_top and shares its clock.
`timescale 1ns/1ps
module opactl_checker
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [21:0] overrideSources,
	input wire opactl_pkg::opactl_analog_t analogCtrl
);
	// ========
	// Shadow copies of what software wrote.
	logic [7:0] ctlQ;
	logic [4:0] codeQ;
	logic q;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctlQ <= 8'h00;
			codeQ <= 5'h00;
		end
		else if (write && !waitrequest && byteenable[0] && address[3:2] == 2'h0)
			ctlQ <= writedata[7:0] & 8'h97;
		else if (write && !waitrequest && byteenable[0] && address[3:2] == 2'h3)
			codeQ <= writedata[4:0];
	end
	// Reserved codes select nothing, so they read as a low source.
	assign q = (codeQ < 5'h16 ? overrideSources[codeQ] : 1'b0) == ctlQ[2];
	// ========
	// Properties.
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	a_power_follow: assert property (analogCtrl.ampPower == $past(ctlQ[7]))
		else $error("power mismatch");
	a_highz_enable: assert property (analogCtrl.portDriverHighZ == $past(ctlQ[7]))
		else $error("high impedance mismatch");
	a_tristate_override: assert property (analogCtrl.ampOutEnable ==
		($past(ctlQ[7]) && !($past(ctlQ[1:0]) == 2'h1 && $past(q, 2)))) else $error("tristate mismatch");
	a_unity_override: assert property (analogCtrl.feedbackClosed ==
		($past(ctlQ[4]) || ($past(ctlQ[1:0]) == 2'h2 && $past(q, 2)))) else $error("unity mismatch");
	a_wait_first: assert property ($rose(read || write) |-> waitrequest)
		else $error("no wait state");
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait too long");
	a_ctl_readback: assert property (read && !waitrequest && address[3:2] == 2'h0 |->
		readdata == {24'h000000, ctlQ}) else $error("readback mismatch");
	a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper bits set");
	// The output flop still holds its reset value at the first edge after release.
	a_pin_release: assert property (analogCtrl.invPinConnected == ($past(nrst) && !analogCtrl.feedbackClosed))
		else $error("inverting pin mismatch");
	cover property (analogCtrl.feedbackClosed && !analogCtrl.ampPower);
	cover property (analogCtrl.ampPower && !analogCtrl.ampOutEnable);
	cover property (read && !waitrequest);
endmodule
bind opactl_top opactl_checker opactl_checker_i (.clock, .nrst, .address, .read, .write, .writedata,
	.byteenable, .readdata, .waitrequest, .overrideSources, .analogCtrl);

/* File: test/opactl_tb_top.sv */
// Self-checking bench for the op amp control block.
// Assumes opactl_top and its checker are compiled first.
`timescale 1ns/1ps
module opactl_tb_top;
	typedef struct packed {logic [7:0] c; logic s; logic [2:0] e;} opactl_row_t;
	logic clock = 0;
	logic nrst = 0;
	logic [3:0] address = 4'h0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h1;
	logic [21:0] overrideSources = 22'h0;
	logic [31:0] readdata;
	logic [31:0] rd;
	logic waitrequest;
	opactl_pkg::opactl_analog_t analogCtrl;
	int miscompares = 0;
	int tests_run = 0;
	int cyc = 0;
	// Control byte, source level, expected power, output enable, feedback.
	opactl_row_t rows [8] = '{'{8'h80, 1'b0, 3'h6}, '{8'h81, 1'b0, 3'h4}, '{8'h85, 1'b0, 3'h6},
		'{8'h85, 1'b1, 3'h4}, '{8'h82, 1'b1, 3'h6}, '{8'h86, 1'b1, 3'h7}, '{8'hff, 1'b1, 3'h7},
		'{8'h02, 1'b0, 3'h1}};
	always #25 clock = ~clock;
	opactl_top opactl_top_i (.clock, .nrst, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .overrideSources, .analogCtrl);
	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
		tests_run++;
		if (v !== e)
		begin
			$display("BAD %s exp %h got %h", n, e, v);
			miscompares++;
		end
	endtask
	// A request is held until waitrequest is seen low, then one idle cycle follows.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	// ========
	// Main sequence.
	initial
	begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		bus(0, 4'h0, 32'h0);
		chk("ctl reset", 32'h0, rd);
		bus(0, 4'hc, 32'h0);
		chk("src reset", 32'h0, rd);
		bus(1, 4'hc, 32'h15);
		for (int i = 0; i < 8; i++)
		begin
			overrideSources <= {22{rows[i].s}};
			bus(1, 4'h0, {24'h0, rows[i].c});
			repeat (3) @(posedge clock);
			chk("analog", {29'h0, rows[i].e}, {29'h0, analogCtrl.ampPower, analogCtrl.ampOutEnable, analogCtrl.feedbackClosed});
			bus(0, 4'h0, 32'h0);
			chk("ctl read", {24'h0, rows[i].c & 8'h97}, rd);
			$display("row %0d done", i);
		end
		overrideSources <= 22'h3fffff;
		bus(1, 4'hc, 32'h16);
		bus(1, 4'h0, 32'h85);
		repeat (3) @(posedge clock);
		chk("reserved", 32'h1, {31'h0, analogCtrl.ampOutEnable});
		overrideSources <= 22'h0;
		bus(1, 4'h0, 32'h84);
		bus(1, 4'h4, 32'h9);
		bus(1, 4'h8, 32'h6);
		byteenable <= 4'he;
		bus(1, 4'h4, 32'h3);
		byteenable <= 4'h1;
		repeat (2) @(posedge clock);
		chk("select", 32'h96, {24'h0, analogCtrl.invSource, analogCtrl.nonInvSource});
		$display("select test done");
		nrst <= 1'b0;
		@(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		bus(0, 4'h0, 32'h0);
		chk("mid reset", 32'h0, rd | analogCtrl.ampPower);
		$display("reset test done");
		end_sim;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			miscompares++;
			end_sim;
		end
	end
endmodule
